// ===== cmg_gap_sequencer.v
// Purpose: Uplink compressed-mode gap sequencer with a Wishbone register port.
// Assumes: One 100 MHz clock; trigger pins are asynchronous to it.
// Notes:   Slot timing is a divided enable; the data path sits outside this block.
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cmg_defs.vh"

module cmg_gap_sequencer #(
	parameter [16:0] SLOT_CYCLES = `CMG_SLOT_CYCLES
) (
	input  wire        CLK,                     // System clock.
	input  wire        SYS_RST,                 // Synchronous reset, active high.
	input  wire        WB_CYC_I,                // Bus cycle.
	input  wire        WB_STB_I,                // Bus strobe.
	input  wire        WB_WE_I,                 // Write enable.
	input  wire [7:0]  WB_ADR_I,                // Byte address.
	input  wire [3:0]  WB_SEL_I,                // Byte lane selects.
	input  wire [31:0] WB_DAT_I,                // Write data.
	output wire [31:0] WB_DAT_O,                // Read data.
	output wire        WB_ACK_O,                // Acknowledge.
	input  wire        START_TRIG_IN,           // External start trigger pin.
	input  wire        STOP_TRIG_IN,            // External stop trigger pin.
	output wire        SLOT_STROBE,             // One-cycle pulse per slot.
	output wire        FRAME_STROBE,            // One-cycle pulse per frame.
	output wire [7:0]  CFN_OUT,                 // Connection frame number.
	output wire [3:0]  SLOT_OUT,                // Slot within the frame.
	output wire        TX_ON,                   // Low during gap slots.
	output wire        COMP_FRAME,              // High during a compressed frame.
	output wire [7:0]  COMPRESSED_POWER_OFFSET, // Power offset in dB, zero otherwise.
	output wire        COMP_EVENT,              // Compressed frame event pulse.
	output wire        ARMED                    // Compressed mode armed.
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WAIT = 2'h1;
	localparam [1:0] ST_RUN  = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	reg         ack_q;
	reg  [31:0] dat_q;
	reg  [31:0] p_ctrl_q, p_gap_q, p_pat_q, p_cfn_q;
	reg  [31:0] a_ctrl_q, a_gap_q, a_pat_q, a_cfn_q;
	reg         pend_q;
	reg  [2:0]  st_sync_q, sp_sync_q;
	reg  [16:0] div_q;
	reg  [3:0]  slot_q;
	reg  [7:0]  cfn_q;
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg         armed_q;
	reg         armed_d;
	reg  [11:0] pos_q;
	reg  [7:0]  fidx_q, pcnt_q;
	reg         gap_q, comp_q, event_q, ftick_q;
	reg  [7:0]  pwr_q;

	////////////////////////////////////////////////////////////////////////////////
	// Byte-lane merge for writes.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wdat;
		input [3:0]  sel;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					merge[i*8 +: 8] = wdat[i*8 +: 8];
				end
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode: a write takes effect on the edge where ack is sampled high.
	wire bus_req = WB_CYC_I & WB_STB_I;
	wire wr_en   = bus_req & WB_WE_I & ack_q;
	wire cmd_wr  = wr_en & (WB_ADR_I == `CMG_ADR_CMD) & WB_SEL_I[0];
	wire sw_apply = cmd_wr & WB_DAT_I[`CMG_CMD_APPLY];
	wire sw_start = cmd_wr & WB_DAT_I[`CMG_CMD_START];
	wire sw_stop  = cmd_wr & WB_DAT_I[`CMG_CMD_STOP];
	wire par_wr   = wr_en & ((WB_ADR_I == `CMG_ADR_CTRL) | (WB_ADR_I == `CMG_ADR_GAP) |
	                         (WB_ADR_I == `CMG_ADR_PAT) | (WB_ADR_I == `CMG_ADR_CFN));

	////////////////////////////////////////////////////////////////////////////////
	// Active parameter fields; only the applied copy steers the sequencer.
	wire       tgps      = a_ctrl_q[`CMG_CTRL_TGPS];
	wire       evsel     = a_ctrl_q[`CMG_CTRL_EVSEL];
	wire       stop_en   = a_ctrl_q[`CMG_CTRL_STOPE];
	wire [3:0] tgsn      = a_gap_q[3:0];
	wire [3:0] tgl1      = a_gap_q[7:4];
	wire [3:0] tgl2      = a_gap_q[11:8];
	wire [8:0] tgd       = a_gap_q[24:16];
	wire [7:0] tgpl1     = a_pat_q[7:0];
	wire [7:0] tgpl2     = a_pat_q[15:8];
	wire [7:0] tgprc     = a_pat_q[23:16];
	wire [7:0] tgcfn     = a_cfn_q[7:0];
	wire [7:0] stop_cfn  = a_cfn_q[15:8];
	wire [7:0] pwr_off   = a_cfn_q[23:16];

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave with one wait state; unmapped reads return zero.
	always @(posedge CLK) begin
		if (SYS_RST) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (bus_req & ~ack_q & ~WB_WE_I) begin
				if (WB_ADR_I == `CMG_ADR_CTRL) begin
					dat_q <= p_ctrl_q & `CMG_MASK_CTRL;
				end else if (WB_ADR_I == `CMG_ADR_GAP) begin
					dat_q <= p_gap_q & `CMG_MASK_GAP;
				end else if (WB_ADR_I == `CMG_ADR_PAT) begin
					dat_q <= p_pat_q & `CMG_MASK_PAT;
				end else if (WB_ADR_I == `CMG_ADR_CFN) begin
					dat_q <= p_cfn_q & `CMG_MASK_CFN;
				end else if (WB_ADR_I == `CMG_ADR_STATUS) begin
					dat_q <= {8'h00, pcnt_q, slot_q, cfn_q, gap_q, pend_q, (state_q == ST_RUN), armed_q};
				end else begin
					dat_q <= 32'h0000_0000;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pending and active parameter sets; apply copies pending to active.
	always @(posedge CLK) begin
		if (SYS_RST) begin
			p_ctrl_q <= `CMG_RST_CTRL;
			p_gap_q  <= `CMG_RST_GAP;
			p_pat_q  <= `CMG_RST_PAT;
			p_cfn_q  <= `CMG_RST_CFN;
			a_ctrl_q <= `CMG_RST_CTRL;
			a_gap_q  <= `CMG_RST_GAP;
			a_pat_q  <= `CMG_RST_PAT;
			a_cfn_q  <= `CMG_RST_CFN;
			pend_q   <= 1'b0;
		end else begin
			if (wr_en & (WB_ADR_I == `CMG_ADR_CTRL)) begin
				p_ctrl_q <= merge(p_ctrl_q, WB_DAT_I, WB_SEL_I) & `CMG_MASK_CTRL;
			end
			if (wr_en & (WB_ADR_I == `CMG_ADR_GAP)) begin
				p_gap_q <= merge(p_gap_q, WB_DAT_I, WB_SEL_I) & `CMG_MASK_GAP;
			end
			if (wr_en & (WB_ADR_I == `CMG_ADR_PAT)) begin
				p_pat_q <= merge(p_pat_q, WB_DAT_I, WB_SEL_I) & `CMG_MASK_PAT;
			end
			if (wr_en & (WB_ADR_I == `CMG_ADR_CFN)) begin
				p_cfn_q <= merge(p_cfn_q, WB_DAT_I, WB_SEL_I) & `CMG_MASK_CFN;
			end
			// Edits wait here until applied; only one sequence set exists.
			if (sw_apply) begin
				a_ctrl_q <= p_ctrl_q;
				a_gap_q  <= p_gap_q;
				a_pat_q  <= p_pat_q;
				a_cfn_q  <= p_cfn_q;
			end
			// A parameter write in the apply cycle keeps the flag set.
			if (par_wr) begin
				pend_q <= 1'b1;
			end else if (sw_apply) begin
				pend_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger pin synchronisers; edges are taken from the second and third stages.
	always @(posedge CLK) begin
		if (SYS_RST) begin
			st_sync_q <= 3'h0;
			sp_sync_q <= 3'h0;
		end else begin
			st_sync_q <= {st_sync_q[1:0], START_TRIG_IN};
			sp_sync_q <= {sp_sync_q[1:0], STOP_TRIG_IN};
		end
	end

	wire ext_start = st_sync_q[1] & ~st_sync_q[2];
	wire ext_stop  = sp_sync_q[1] & ~sp_sync_q[2];

	////////////////////////////////////////////////////////////////////////////////
	// Slot divider, slot counter and CFN counter, running from reset onward.
	wire slot_tick  = (div_q == SLOT_CYCLES - 17'h00001);
	wire frame_tick = slot_tick & (slot_q == `CMG_LAST_SLOT);

	always @(posedge CLK) begin
		if (SYS_RST) begin
			div_q  <= 17'h00000;
			slot_q <= 4'h0;
			cfn_q  <= 8'h00;
		end else begin
			div_q <= slot_tick ? 17'h00000 : div_q + 17'h00001;
			if (frame_tick) begin
				slot_q <= 4'h0;
				cfn_q  <= cfn_q + 8'h01;
			end else if (slot_tick) begin
				slot_q <= slot_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gap windows measured in slots from the start of the current pattern.
	wire [11:0] g1s   = {8'h00, tgsn};
	wire [11:0] g1e   = g1s + {8'h00, tgl1};
	wire [11:0] g2s   = g1s + {3'h0, tgd};
	wire [11:0] g2e   = g2s + {8'h00, tgl2};
	wire        two   = (tgd != 9'h000) & (tgl2 != 4'h0);
	wire [11:0] fb    = pos_q - {8'h00, slot_q};
	wire [11:0] fe    = fb + {8'h00, `CMG_SLOTS_PER_FRAME};
	wire        run   = (state_q == ST_RUN) & tgps;
	wire        in_g1 = (pos_q >= g1s) & (pos_q < g1e);
	wire        in_g2 = two & (pos_q >= g2s) & (pos_q < g2e);
	wire        fr_g1 = (tgl1 != 4'h0) & (g1s < fe) & (g1e > fb);
	wire        fr_g2 = two & (g2s < fe) & (g2e > fb);
	wire        comp_w = run & (fr_g1 | fr_g2);

	// Pattern bookkeeping: odd patterns use the second length.
	wire [7:0] plen     = pcnt_q[0] ? tgpl2 : tgpl1;
	wire       pat_end  = frame_tick & (fidx_q + 8'h01 >= plen);
	wire       cnt_done = pat_end & (tgprc != 8'h00) & (pcnt_q + 8'h01 == tgprc);
	wire       cfn_done = frame_tick & stop_en & (cfn_q == stop_cfn);
	wire       seq_done = (state_q == ST_RUN) & (cnt_done | cfn_done);
	wire       start_ev = sw_start | ext_start;
	wire       stop_ev  = sw_stop | ext_stop | sw_apply;

	////////////////////////////////////////////////////////////////////////////////
	// Armed flag: a start in the same cycle as a clear wins.
	always @* begin
		armed_d = armed_q;
		if (start_ev) begin
			armed_d = 1'b1;
		end else if (stop_ev | seq_done) begin
			armed_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer next state.
	always @* begin
		state_d = state_q;
		if (stop_ev | seq_done) begin
			state_d = ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (armed_q) begin
						state_d = ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (frame_tick & tgps & (cfn_q + 8'h01 == tgcfn)) begin
						state_d = ST_RUN;
					end
				end
				ST_RUN: begin
					state_d = ST_RUN;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer registers: pattern position, frame index and pattern count.
	always @(posedge CLK) begin
		if (SYS_RST) begin
			state_q <= ST_IDLE;
			armed_q <= 1'b0;
			pos_q   <= 12'h000;
			fidx_q  <= 8'h00;
			pcnt_q  <= 8'h00;
		end else begin
			state_q <= state_d;
			armed_q <= armed_d;
			if (state_q != ST_RUN) begin
				pos_q  <= 12'h000;
				fidx_q <= 8'h00;
				if (state_d == ST_RUN) begin
					pcnt_q <= 8'h00;
				end
			end else if (pat_end) begin
				pos_q  <= 12'h000;
				fidx_q <= 8'h00;
				pcnt_q <= pcnt_q + 8'h01;
			end else if (frame_tick) begin
				pos_q  <= pos_q + 12'h001;
				fidx_q <= fidx_q + 8'h01;
			end else if (slot_tick) begin
				pos_q <= pos_q + 12'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs: gap blanking, compressed-frame flag, offset and event.
	always @(posedge CLK) begin
		if (SYS_RST) begin
			gap_q   <= 1'b0;
			comp_q  <= 1'b0;
			pwr_q   <= 8'h00;
			event_q <= 1'b0;
			ftick_q <= 1'b0;
		end else begin
			ftick_q <= frame_tick;
			// Counters keep running through gaps; only transmission is blanked.
			gap_q   <= run & (in_g1 | in_g2);
			comp_q  <= comp_w;
			// Coding is untouched here, so compressed frames stay fully coded.
			pwr_q   <= comp_w ? pwr_off : 8'h00;
			event_q <= evsel & comp_w & (~comp_q | ftick_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output assignments.
	assign WB_DAT_O                = dat_q;
	assign WB_ACK_O                = ack_q;
	assign SLOT_STROBE             = slot_tick;
	assign FRAME_STROBE            = frame_tick;
	assign CFN_OUT                 = cfn_q;
	assign SLOT_OUT                = slot_q;
	assign TX_ON                   = ~gap_q;
	assign COMP_FRAME              = comp_q;
	assign COMPRESSED_POWER_OFFSET = pwr_q;
	assign COMP_EVENT              = event_q;
	assign ARMED                   = armed_q;

endmodule

// ===== cmg_defs.vh
// Purpose: Constants for the compressed-mode gap sequencer.
// Assumes: Included by bare name; 32-bit Wishbone register words.
// Notes:   Offsets are byte addresses; field positions are low bits.
`ifndef CMG_DEFS_VH
`define CMG_DEFS_VH

// Timing.
`define CMG_CLK_PERIOD_NS   10
`define CMG_SLOT_NS         666667
// Clocks per slot: one slot time over the clock period, sized to the divider.
`define CMG_SLOT_CYCLES     17'h1046a
`define CMG_SLOTS_PER_FRAME 4'hf
`define CMG_LAST_SLOT       4'he

// Register byte offsets.
`define CMG_ADR_CTRL   8'h00
`define CMG_ADR_CMD    8'h04
`define CMG_ADR_GAP    8'h08
`define CMG_ADR_PAT    8'h0c
`define CMG_ADR_CFN    8'h10
`define CMG_ADR_STATUS 8'h14

// Readable bit masks of the writable registers.
`define CMG_MASK_CTRL 32'h0000_0007
`define CMG_MASK_GAP  32'h01ff_0fff
`define CMG_MASK_PAT  32'h00ff_ffff
`define CMG_MASK_CFN  32'h00ff_ffff

// Reset values.
`define CMG_RST_CTRL 32'h0000_0000
`define CMG_RST_GAP  32'h0000_0078
`define CMG_RST_PAT  32'h0000_0101
`define CMG_RST_CFN  32'h0000_0000

// Control and command bits.
`define CMG_CTRL_TGPS  0
`define CMG_CTRL_EVSEL 1
`define CMG_CTRL_STOPE 2
`define CMG_CMD_APPLY  0
`define CMG_CMD_START  1
`define CMG_CMD_STOP   2

`endif

// ===== cmg_properties.sv
// Purpose: Concurrent checks on the gap sequencer ports.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Attached to every sequencer instance by the bind below.
`timescale 1ns/1ps
module cmg_properties #(
	parameter [16:0] SLOT_CYCLES = 17'h1046a
) (
	input wire       CLK,                     // Clock.
	input wire       SYS_RST,                 // Reset.
	input wire       WB_CYC_I,                // Bus cycle.
	input wire       WB_STB_I,                // Bus strobe.
	input wire       WB_ACK_O,                // Bus acknowledge.
	input wire       START_TRIG_IN,           // Start pin.
	input wire       STOP_TRIG_IN,            // Stop pin.
	input wire       SLOT_STROBE,             // Slot pulse.
	input wire       FRAME_STROBE,            // Frame pulse.
	input wire [7:0] CFN_OUT,                 // Frame number.
	input wire [3:0] SLOT_OUT,                // Slot number.
	input wire       TX_ON,                   // Low in gaps.
	input wire       COMP_FRAME,              // Compressed frame.
	input wire [7:0] COMPRESSED_POWER_OFFSET, // Offset in dB.
	input wire       COMP_EVENT,              // Frame event.
	input wire       ARMED                    // Armed status.
);
	logic [16:0] cnt_q;
	logic        seen_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////////////////////////
	// Count the clocks between slot strobes; the first slot is skipped.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cnt_q  <= 17'h0;
			seen_q <= 1'b0;
		end else if (SLOT_STROBE) begin
			cnt_q  <= 17'h0;
			seen_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 17'h1;
		end
	end
	////////////////////////////////////////////////////////////
	// Named steps shared by the properties.
	sequence s_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_arm_edge;
		$rose(START_TRIG_IN);
	endsequence
	sequence s_comp_rise;
		$rose(COMP_FRAME);
	endsequence
	// Bus, slot, frame, gap and arming relations.
	ack_follows_req_a: assert property (s_req |=> WB_ACK_O) else $error("ack missing after request");
	ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
	slot_period_a: assert property (SLOT_STROBE && seen_q |-> cnt_q == SLOT_CYCLES - 17'h1)
		else $error("slot length wrong");
	frame_on_last_a: assert property (FRAME_STROBE |-> SLOT_STROBE && SLOT_OUT == 4'he)
		else $error("frame strobe off the last slot");
	cfn_step_a: assert property ($changed(CFN_OUT) |-> CFN_OUT == $past(CFN_OUT) + 8'h01)
		else $error("frame number step wrong");
	gap_in_comp_a: assert property (!TX_ON |-> COMP_FRAME) else $error("gap outside compressed frame");
	offset_idle_a: assert property (!COMP_FRAME |-> COMPRESSED_POWER_OFFSET == 8'h00)
		else $error("offset outside compressed frame");
	event_pulse_a: assert property (COMP_EVENT |-> COMP_FRAME ##1 !COMP_EVENT)
		else $error("event pulse wrong");
	comp_needs_arm_a: assert property (s_comp_rise |-> $past(ARMED) && SLOT_OUT == 4'h0)
		else $error("compressed frame without arming");
	arm_on_trig_a: assert property (s_arm_edge |-> ##[1:4] ARMED) else $error("start pin did not arm");
	stop_on_trig_a: assert property ($rose(STOP_TRIG_IN) |-> ##[1:4] !ARMED)
		else $error("stop pin did not disarm");
endmodule
bind cmg_gap_sequencer cmg_properties #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .START_TRIG_IN(START_TRIG_IN),
	.STOP_TRIG_IN(STOP_TRIG_IN), .SLOT_STROBE(SLOT_STROBE), .FRAME_STROBE(FRAME_STROBE), .CFN_OUT(CFN_OUT),
	.SLOT_OUT(SLOT_OUT), .TX_ON(TX_ON), .COMP_FRAME(COMP_FRAME), .COMPRESSED_POWER_OFFSET(COMPRESSED_POWER_OFFSET),
	.COMP_EVENT(COMP_EVENT), .ARMED(ARMED));

// ===== cmg_trig_src.sv
// Purpose: Model of the external start and stop trigger sources.
// Assumes: The bench asks for a trigger with a one-cycle request.
// Notes:   Each trigger is a four-clock pulse, longer than the pin sampler.
`timescale 1ns/1ps
module cmg_trig_src (
	input  wire  clk,        // Bench clock.
	input  wire  fire_start, // Start request.
	input  wire  fire_stop,  // Stop request.
	output wire  start_trig, // Start pin.
	output wire  stop_trig   // Stop pin.
);
	logic [2:0] st_q = 3'h0;
	logic [2:0] sp_q = 3'h0;
	// Stretch each request into a pulse that rests low between triggers.
	always @(posedge clk) begin
		st_q <= fire_start ? 3'h4 : ((st_q != 3'h0) ? st_q - 3'h1 : 3'h0);
		sp_q <= fire_stop ? 3'h4 : ((sp_q != 3'h0) ? sp_q - 3'h1 : 3'h0);
	end
	assign start_trig = (st_q != 3'h0);
	assign stop_trig  = (sp_q != 3'h0);
endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench for the gap sequencer.
// Assumes: Slots shortened to 20 clocks; triggers come from the model.
// Notes:   The gap map is taken per slot from TX_ON and compared per frame.
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, fs = 0, fp = 0, clr = 0;
	logic [7:0] adr = 8'h0, tgcfn, pl1, pl2, prc, ofs_v;
	logic [31:0] wdat = 32'h0, rd, dat_o;
	logic [3:0] sel = 4'hf, tgsn, tgl1, tgl2, slot;
	logic [8:0] tgd;
	logic [15:0] lf = 16'ha02c;
	logic [14:0] gapm [256];
	logic cfm [256];
	wire ack, st, sp, ss, fst, txon, cf, ev, armed;
	wire [7:0] cfn, ofs;
	int errors = 0, n_checks = 0, n_cyc = 0, n_gap = 0, n_ev = 0, bad_ofs = 0, i, ne;
	cmg_gap_sequencer #(.SLOT_CYCLES(17'h14)) u_dut (.CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.START_TRIG_IN(st), .STOP_TRIG_IN(sp), .SLOT_STROBE(ss), .FRAME_STROBE(fst), .CFN_OUT(cfn),
		.SLOT_OUT(slot), .TX_ON(txon), .COMP_FRAME(cf), .COMPRESSED_POWER_OFFSET(ofs), .COMP_EVENT(ev),
		.ARMED(armed));
	cmg_trig_src u_src (.clk(clk), .fire_start(fs), .fire_stop(fp), .start_trig(st), .stop_trig(sp));
	////////////////////////////////////////////////////////////
	// Clock and the monitor of gaps, events, offset and run time.
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (clr) begin
			foreach (gapm[j]) gapm[j] <= 15'h0;
			{n_gap, n_ev, bad_ofs} <= 96'h0;
		end else begin
			if (ss === 1'b1) begin
				gapm[cfn][slot] <= !txon;
				cfm[cfn] <= cf;
			end
			n_gap <= n_gap + (txon !== 1'b1);
			n_ev <= n_ev + (ev === 1'b1);
			bad_ofs <= bad_ofs + (cf === 1'b1 && ofs !== ofs_v);
		end
		n_cyc <= n_cyc + 1;
		if (n_cyc == 40000) begin
			errors++;
			stop_test;
		end
	end
	////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One classic Wishbone access; waits for ack, then releases.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dat_o;
		{cyc, stb, we} <= 3'h0;
		if (n >= 50) chk("ack", 32'h0, 32'h1);
	endtask
	// Write all parameters with a start frame three frames ahead, then apply.
	task cfg(input logic [31:0] ctrl);
		tgcfn = cfn + 8'h03;
		wb(1'b1, 8'h08, {7'h0, tgd, 4'h0, tgl2, tgl1, tgsn});
		wb(1'b1, 8'h0c, {8'h0, prc, pl2, pl1});
		wb(1'b1, 8'h10, {8'h0, ofs_v, tgcfn + 8'h01, tgcfn});
		wb(1'b1, 8'h00, ctrl);
		wb(1'b1, 8'h04, 32'h1);
	endtask
	task wait_cfn(input logic [7:0] c);
		int n;
		n = 0;
		while (cfn !== c && n < 9000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 9000) chk("frame wait", 32'h0, 32'h1);
	endtask
	// Clear the monitor's counters and gap map at the second clock edge from the call.
	task clr_mon;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	task pulse_stop;
		@(posedge clk);
		fp <= 1'b1;
		@(posedge clk);
		fp <= 1'b0;
	endtask
	function logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function int plen(input int p);
		int l;
		l = p[0] ? int'(pl2) : int'(pl1);
		return (l == 0) ? 1 : l;
	endfunction
	// Gap slots expected in frame f of the sequence.
	function logic [14:0] exp_mask(input int f);
		int p, b, k, s;
		exp_mask = 15'h0;
		p = 0;
		b = 0;
		while (f >= b + plen(p)) begin
			b += plen(p);
			p++;
		end
		for (s = 0; s < 15; s++) begin
			k = (f - b) * 15 + s;
			if ((prc == 0 || p < prc) && ((k >= tgsn && k < tgsn + tgl1) || (k >= tgsn + tgd && k < tgsn + tgd + tgl2)))
				exp_mask[s] = 1'b1;
		end
	endfunction
	////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
		logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h78, 32'h101, 32'h0, 32'h0};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 6; i++) begin
			wb(1'b0, ra[i], 32'h0);
			chk("reset value", rd, rv[i]);
		end
		wb(1'b1, 8'h18, 32'hffffffff);
		wb(1'b0, 8'h18, 32'h0);
		chk("unmapped read", rd, 32'h0);
		$display("test registers done");
		{tgsn, tgl1, tgl2, tgd, pl1, pl2, prc} = {4'ha, 4'h8, 4'h3, 9'h14, 8'h3, 8'h3, 8'h2};
		lf = lfsr_next(lf);
		ofs_v = lf[7:0];
		cfg(32'h3);
		clr_mon;
		wait_cfn(tgcfn + 8'h2);
		chk("gaps without start", n_gap, 32'h0);
		chk("armed without start", armed, 32'h0);
		cfg(32'h2);
		wb(1'b1, 8'h04, 32'h2);
		clr_mon;
		wait_cfn(tgcfn + 8'h2);
		chk("gaps with support off", n_gap, 32'h0);
		$display("test no gaps done");
		cfg(32'h3);
		clr_mon;
		@(posedge clk);
		fs <= 1'b1;
		@(posedge clk);
		fs <= 1'b0;
		repeat (6) @(posedge clk);
		chk("armed by pin", armed, 32'h1);
		lf = lfsr_next(lf);
		wb(1'b1, 8'h08, {lf, lf});
		wb(1'b0, 8'h08, 32'h0);
		chk("pending readback", rd, {lf, lf} & 32'h01ff0fff);
		wait_cfn(tgcfn + 8'h8);
		ne = 0;
		for (i = 0; i < 8; i++) begin
			chk("gap map", gapm[tgcfn + i[7:0]], exp_mask(i));
			chk("compressed frame", cfm[tgcfn + i[7:0]], exp_mask(i) != 15'h0);
			ne += (exp_mask(i) != 15'h0);
		end
		chk("event count", n_ev, ne);
		chk("offset", bad_ofs, 32'h0);
		chk("disarm after count", armed, 32'h0);
		$display("test pattern run done");
		prc = 8'h0;
		clr_mon;
		// The last round stops on the stop frame number, one frame after the start frame.
		for (i = 0; i < 4; i++) begin
			cfg((i == 3) ? 32'h5 : 32'h1);
			wb(1'b1, 8'h04, 32'h2);
			wait_cfn(tgcfn + 8'h1);
			case (i)
				0: wb(1'b1, 8'h04, 32'h1);
				1: wb(1'b1, 8'h04, 32'h4);
				2: pulse_stop;
				default: wait_cfn(tgcfn + 8'h2);
			endcase
			repeat (20) @(posedge clk);
			chk("armed after stop", armed, 32'h0);
			repeat (600) @(posedge clk);
			chk("output after stop", {cf, txon}, 32'h1);
			if (i == 3) begin
				chk("frame before stop", cfm[tgcfn + 8'h1], 32'h1);
				chk("frame after stop", cfm[tgcfn + 8'h2], 32'h0);
			end
		end
		chk("events while off", n_ev, 32'h0);
		$display("test stops done");
		stop_test;
	end
endmodule
